/* File: pod_defs.svh */
// Purpose: numeric constants of the pwm output-disable unit
// Assumes: included by bare name in the package and the bench; the other files use its macros without an include
// Notes: offsets are byte addresses on the apb slave
`ifndef POD_DEFS_SVH
`define POD_DEFS_SVH
// ****************************************
// register map
// ****************************************
`define POD_OFS_MODE    8'h00
`define POD_OFS_ALVL    8'h04
`define POD_OFS_SWREQ   8'h08
`define POD_OFS_CH0EN   8'h0C
`define POD_OFS_STAT    8'h10
`define POD_OFS_MASK    8'h14
`define POD_OFS_PINS    8'h18
// ****************************************
// fields and counts
// ****************************************
`define POD_SW34_BIT    0
`define POD_SWALL_BIT   1
`define POD_CH0C_BIT    0
`define POD_CH0D_BIT    1
`define POD_ST_FLT      0
`define POD_ST_SHORT    3
`define POD_ST_OSC      6
`define POD_ST_CMP      7
`define POD_PIN_CH0C    2
`define POD_PIN_CH0D    3
`define POD_PIN_PAIR    4
`define POD_SAMPLES     5'h10
`define POD_DIV8_MASK   7'h07
`define POD_DIV16_MASK  7'h0F
`define POD_DIV128_MASK 7'h7F
`endif

/* File: pod_pkg.sv */
// Purpose: shared types of the pwm output-disable unit
// Assumes: pod_defs.svh holds every numeric constant
// Notes: sample tick decode is shared by all fault inputs
package pod_pkg;
`include "pod_defs.svh"
  typedef enum logic [1:0] {POD_EDGE, POD_DIV8, POD_DIV16, POD_DIV128} pod_mode_t;

  function automatic logic pod_tick(input pod_mode_t m, input logic [6:0] c);
    logic [6:0] msk;
    case (m)
      POD_DIV8:  msk = `POD_DIV8_MASK;
      POD_DIV16: msk = `POD_DIV16_MASK;
      default:   msk = `POD_DIV128_MASK;
    endcase
    return (c & msk) == msk;
  endfunction
endpackage

/* File: pod_flt_if.sv */
// Purpose: link between the top and one fault input detector
// Assumes: all signals on the top clock
// Notes: hit is a level in sampled modes, a pulse in edge mode
`timescale 1ns/1ps
interface pod_flt_if
  import pod_pkg::*;
  ();
  pod_mode_t mode;
  logic      tick;
  logic      lvl_n;
  logic      hit;
  modport det (input mode, input tick, input lvl_n, output hit);
  modport ctl (output mode, output tick, output lvl_n, input hit);
endinterface

/* File: pod_fault_det.sv */
// Purpose: falling edge or sampled low-level detector
// Assumes: lvl_n is already synchronised
// Notes: one high sample restarts the low count
`timescale 1ns/1ps
module pod_fault_det
  import pod_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // fault link
  pod_flt_if.det   flt
);
  logic       lvl_q;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  wire        lvl_mode = (flt.mode != POD_EDGE);
  wire        full     = (cnt_q == `POD_SAMPLES);

  always_comb begin
    cnt_d = cnt_q;
    if (!lvl_mode)
      cnt_d = '0;
    else if (flt.tick)
      cnt_d = flt.lvl_n ? '0 : (full ? cnt_q : cnt_q + 5'h01);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lvl_q <= 1'b1;
      cnt_q <= '0;
    end else begin
      lvl_q <= flt.lvl_n;
      cnt_q <= cnt_d;
    end
  end

  assign flt.hit = lvl_mode ? full : (lvl_q & ~flt.lvl_n);

  property p_lvl_count;
    @(posedge clk_i) disable iff (!rst_n_i)
      lvl_mode && $rose(full) |-> $past(flt.tick) && !$past(flt.lvl_n);
  endproperty
  a_lvl_count: assert property (p_lvl_count) else $error("low count grew without low sample");
endmodule

/* File: pod_short_cmp.sv */
// Purpose: simultaneous active level check of one pin pair
// Assumes: timer levels come from the same clock
// Notes: registered so a one-cycle overlap is enough
`timescale 1ns/1ps
module pod_short_cmp (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // pair levels and their active levels
  input  wire logic a_i,
  input  wire logic b_i,
  input  wire logic al_a_i,
  input  wire logic al_b_i,
  // result
  output logic      short_o
);
  wire both_act = (a_i == al_a_i) && (b_i == al_b_i);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      short_o <= 1'b0;
    else
      short_o <= both_act;
  end

  property p_short;
    @(posedge clk_i) disable iff (!rst_n_i)
      (a_i == al_a_i) && (b_i == al_b_i) |=> short_o;
  endproperty
  a_short: assert property (p_short) else $error("short of pair not flagged");
endmodule

/* File: pod_top.sv */
// Purpose: output-disable unit for complementary pwm timer pins
// Assumes: apb master on clk_i, fault and event inputs asynchronous
// Notes: pin order ch0 a,b,c,d, ch3 b,d, ch4 a,c, ch4 b,d
`timescale 1ns/1ps
module pod_top
  import pod_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // apb slave
  input  wire logic [7:0]  paddr_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // fault sources
  input  wire logic        fault_input_a_n_i,
  input  wire logic        fault_input_b_n_i,
  input  wire logic        fault_input_c_n_i,
  input  wire logic        osc_stop_i,
  input  wire logic        analog_comparator_i,
  // timer side, one bit per pin
  input  wire logic [9:0]  tmr_out_i,
  input  wire logic [9:0]  tmr_oe_i,
  // pin side
  output logic      [9:0]  pin_o,
  output logic      [9:0]  pin_oe_o,
  // interrupt
  output logic             irq_o
);
  // ****************************************
  // reset release
  // ****************************************
  logic [1:0] rsync_q;
  wire        rst_n = rsync_q[1];

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i)
      rsync_q <= '0;
    else
      rsync_q <= {rsync_q[0], 1'b1};
  end

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [2:0] flt1_q;
  logic [2:0] flt2_q;
  logic [1:0] ev1_q;
  logic [1:0] ev2_q;
  wire        osc_s = ev2_q[0];
  wire        cmp_s = ev2_q[1];

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      flt1_q <= 3'h7;
      flt2_q <= 3'h7;
      ev1_q  <= 2'h0;
      ev2_q  <= 2'h0;
    end else begin
      flt1_q <= {fault_input_c_n_i, fault_input_b_n_i, fault_input_a_n_i};
      flt2_q <= flt1_q;
      ev1_q  <= {analog_comparator_i, osc_stop_i};
      ev2_q  <= ev1_q;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  logic [5:0]  mode_q;
  logic [5:0]  alvl_q;
  logic [1:0]  swreq_q;
  logic [1:0]  ch0en_q;
  logic [7:0]  stat_q;
  logic [7:0]  stat_d;
  logic [7:0]  mask_q;
  logic [9:0]  hiz_q;
  logic [6:0]  pre_q;
  logic [31:0] rdata_q;
  logic        ready_q;
  logic        err_q;
  logic        irq_q;
  logic [9:0]  pin_q;
  logic [9:0]  pin_oe_q;

  // ****************************************
  // apb decode
  // ****************************************
  wire access   = psel_i & penable_i;
  wire do_wr    = access & ready_q & pwrite_i;
  wire sel_mode = (paddr_i == `POD_OFS_MODE);
  wire sel_alvl = (paddr_i == `POD_OFS_ALVL);
  wire sel_swr  = (paddr_i == `POD_OFS_SWREQ);
  wire sel_ch0  = (paddr_i == `POD_OFS_CH0EN);
  wire sel_stat = (paddr_i == `POD_OFS_STAT);
  wire sel_mask = (paddr_i == `POD_OFS_MASK);
  wire sel_pins = (paddr_i == `POD_OFS_PINS);
  wire mapped   = sel_mode | sel_alvl | sel_swr | sel_ch0 |
                  sel_stat | sel_mask | sel_pins;
  wire [31:0] rd_word =
      sel_mode ? {26'h0, mode_q}  :
      sel_alvl ? {26'h0, alvl_q}  :
      sel_swr  ? {30'h0, swreq_q} :
      sel_ch0  ? {30'h0, ch0en_q} :
      sel_stat ? {24'h0, stat_q}  :
      sel_mask ? {24'h0, mask_q}  :
      sel_pins ? {22'h0, hiz_q}   : 32'h0;

  // one wait state: ready rises in the second access cycle
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ready_q <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= '0;
    end else begin
      ready_q <= access & ~ready_q;
      err_q   <= access & ~ready_q & ~mapped;
      if (access & ~ready_q)
        rdata_q <= pwrite_i ? 32'h0 : rd_word;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_q  <= '0;
      alvl_q  <= '0;
      swreq_q <= '0;
      ch0en_q <= '0;
      mask_q  <= '0;
    end else if (do_wr) begin
      if (sel_mode)
        mode_q <= pwdata_i[5:0];
      if (sel_alvl)
        alvl_q <= pwdata_i[5:0];
      if (sel_swr)
        swreq_q <= pwdata_i[1:0];
      if (sel_ch0)
        ch0en_q <= pwdata_i[1:0];
      if (sel_mask)
        mask_q <= pwdata_i[7:0];
    end
  end

  // ****************************************
  // fault input detectors
  // ****************************************
  logic [2:0] flt_hit;
  pod_flt_if u_fif[3] ();

  for (genvar i = 0; i < 3; i++) begin : g_flt
    assign u_fif[i].mode  = pod_mode_t'(mode_q[2*i +: 2]);
    assign u_fif[i].tick  = pod_tick(pod_mode_t'(mode_q[2*i +: 2]), pre_q);
    assign u_fif[i].lvl_n = flt2_q[i];
    assign flt_hit[i]     = u_fif[i].hit;
    pod_fault_det u_det (
      .clk_i   (clk_i),
      .rst_n_i (rst_n),
      .flt     (u_fif[i])
    );
  end

  // free running divider for the sampling ticks
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n)
      pre_q <= '0;
    else
      pre_q <= pre_q + 7'h01;
  end

  // ****************************************
  // short circuit comparators
  // ****************************************
  logic [2:0] short;

  for (genvar p = 0; p < 3; p++) begin : g_pair
    pod_short_cmp u_cmp (
      .clk_i   (clk_i),
      .rst_n_i (rst_n),
      .a_i     (tmr_out_i[`POD_PIN_PAIR + 2*p]),
      .b_i     (tmr_out_i[`POD_PIN_PAIR + 2*p + 1]),
      .al_a_i  (alvl_q[2*p]),
      .al_b_i  (alvl_q[2*p + 1]),
      .short_o (short[p])
    );
  end

  // ****************************************
  // detection flags
  // ****************************************
  wire [7:0] src = {cmp_s, osc_s, short, flt_hit};
  wire [7:0] clr = (do_wr & sel_stat) ? pwdata_i[7:0] : 8'h00;

  // a live cause re-sets its flag, so a clear only sticks once it is gone
  always_comb stat_d = src | (stat_q & ~clr);

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n)
      stat_q <= '0;
    else
      stat_q <= stat_d;
  end

  // ****************************************
  // high impedance control
  // ****************************************
  wire flt_any = |stat_q[`POD_ST_FLT +: 3];
  wire sh_any  = |stat_q[`POD_ST_SHORT +: 3];
  wire osc_f   = stat_q[`POD_ST_OSC];
  wire cmp_f   = stat_q[`POD_ST_CMP];
  wire sw34    = swreq_q[`POD_SW34_BIT];
  wire swall   = swreq_q[`POD_SWALL_BIT];
  // ch0 pins are not shorted-pair targets
  wire hiz_ch0 = flt_any | osc_f | cmp_f | swall;
  wire hiz_pwm = hiz_ch0 | sh_any | sw34;
  wire [9:0] hiz = {{6{hiz_pwm}},
                    hiz_ch0 & ch0en_q[`POD_CH0D_BIT],
                    hiz_ch0 & ch0en_q[`POD_CH0C_BIT],
                    {2{hiz_ch0}}};

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      hiz_q    <= '0;
      pin_q    <= '0;
      pin_oe_q <= '0;
      irq_q    <= 1'b0;
    end else begin
      hiz_q    <= hiz;
      pin_q    <= tmr_out_i;
      pin_oe_q <= tmr_oe_i & ~hiz;
      irq_q    <= |(stat_q & mask_q);
    end
  end

  assign pin_o     = pin_q;
  assign pin_oe_o  = pin_oe_q;
  assign irq_o     = irq_q;
  assign prdata_o  = rdata_q;
  assign pready_o  = ready_q;
  assign pslverr_o = err_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  sequence s_flag_set;
    ##1 (|stat_q[`POD_ST_FLT +: 3]);
  endsequence

  sequence s_pins_off;
    ##1 (&hiz_q[9:4]) && (&hiz_q[1:0]);
  endsequence

  property p_hiz_off;
    (|hiz_q) |-> ((pin_oe_o & hiz_q) == 10'h000);
  endproperty
  a_hiz_off: assert property (p_hiz_off) else $error("pin driven while disabled");

  property p_fault_off;
    (|flt_hit) |-> s_flag_set ##0 s_pins_off;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("fault did not disable pins");

  property p_osc_off;
    osc_s |=> stat_q[`POD_ST_OSC] ##0 s_pins_off;
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("osc stop did not disable pins");

  property p_cmp_off;
    cmp_s |-> ##2 (&hiz_q[1:0]) && (&hiz_q[9:4]);
  endproperty
  a_cmp_off: assert property (p_cmp_off) else $error("comparator did not disable pins");

  property p_short_off;
    (|short) |=> (|stat_q[`POD_ST_SHORT +: 3]) ##1 (&hiz_q[9:4]);
  endproperty
  a_short_off: assert property (p_short_off) else $error("short did not disable pwm pins");

  property p_sw34;
    sw34 |=> (&hiz_q[9:4]);
  endproperty
  a_sw34: assert property (p_sw34) else $error("ch3/ch4 software request ignored");

  property p_swall;
    swall && ch0en_q == 2'h3 && $stable(ch0en_q) |=> (&hiz_q);
  endproperty
  a_swall: assert property (p_swall) else $error("software disable missed a pin");

  property p_ch0_excl;
    !ch0en_q[`POD_CH0C_BIT] |=> !hiz_q[`POD_PIN_CH0C] || $past(ch0en_q[`POD_CH0C_BIT]);
  endproperty
  a_ch0_excl: assert property (p_ch0_excl) else $error("ch0 c disabled while excluded");

  property p_sticky;
    (|(stat_q & src)) |=> ((stat_q & $past(stat_q & src)) == $past(stat_q & src));
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag cleared while cause live");

  property p_irq;
    (|(stat_q & mask_q)) |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("unmasked flag gave no interrupt");

  property p_irq_quiet;
    !(|(stat_q & mask_q)) |=> !irq_o;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt without unmasked flag");

  // a set flag may only drop through a write to the status word
  property p_flag_hold;
    (|stat_q) && !(do_wr && sel_stat) |=> ((stat_q & $past(stat_q)) == $past(stat_q));
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost without clear");

  property p_pins_hold;
    (|stat_q) |=> (&hiz_q[9:4]);
  endproperty
  a_pins_hold: assert property (p_pins_hold) else $error("pins released while flag set");

  // the first cycle out of reset is skipped: the output flops were still cleared
  property p_oe_pass;
    $past(rst_n) && !(|hiz) |=> (pin_oe_o == $past(tmr_oe_i));
  endproperty
  a_oe_pass: assert property (p_oe_pass) else $error("enable not passed while allowed");

  property p_pin_pass;
    $past(rst_n) |=> (pin_o == $past(tmr_out_i));
  endproperty
  a_pin_pass: assert property (p_pin_pass) else $error("pin level not passed on");

  property p_ready_pulse;
    pready_o |=> !pready_o;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held for two cycles");

  property p_err_ready;
    pslverr_o |-> pready_o;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("bus error without ready");
endmodule

/* File: pod_tmr_model.sv */
// Purpose: pwm timer model on the far side of the output-disable unit
// Assumes: runs on the unit clock
// Notes: idle pattern keeps every pair one-on one-off for either level
`timescale 1ns/1ps
module pod_tmr_model (
  // clock
  input  wire logic       clk_i,
  // control from the bench
  input  wire logic       en_i,
  input  wire logic [2:0] short_i,
  // timer outputs
  output logic      [9:0] tmr_out_o,
  output logic      [9:0] tmr_oe_o
);
  logic [3:0] cnt_q = 4'h0;
  logic       hi_a;
  logic       hi_b;
  // dead time at counts 0 and 8 leaves both legs low
  assign hi_a     = (cnt_q > 4'h0) && (cnt_q < 4'h8);
  assign hi_b     = cnt_q > 4'h8;
  assign tmr_oe_o = 10'h3FF;
  always @(posedge clk_i) begin
    cnt_q <= cnt_q + 4'h1;
  end
  always_comb begin
    tmr_out_o = 10'h155;
    if (en_i) begin
      tmr_out_o = {5{hi_b, hi_a}};
    end
    for (int k = 0; k < 3; k++) begin
      if (short_i[k]) begin
        tmr_out_o[4 + 2 * k +: 2] = 2'h3;
      end
    end
  end
endmodule

/* File: tb_pwm_output_disable_control.sv */
// Purpose: self-checking bench of the output-disable unit
// Assumes: apb master on clk_i, timer model on the far side
// Notes: apb results go through a queue to a bus monitor
`timescale 1ns/1ps
`include "pod_defs.svh"
module tb_pwm_output_disable_control;
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} pod_exp_t;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic        clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  flt_n = 3'h7;
  logic        osc = 1'b0;
  logic        cmp = 1'b0;
  logic        tm_en = 1'b0;
  logic [2:0]  shrt = 3'h0;
  logic [9:0]  tmr_out;
  logic [9:0]  tmr_oe;
  logic [9:0]  pin_oe;
  logic [9:0]  pin;
  logic [9:0]  tmr_dly;
  logic        irq;
  logic [31:0] lfsr = 32'hA74F;
  pod_exp_t    exp_q[$];
  pod_exp_t    e;
  int          err_count = 0;
  int          checks = 0;

  initial forever #5 clk_i = ~clk_i;

  pod_top i_pod_top (.clk_i(clk_i), .rstn_i(rstn_i), .paddr_i(paddr), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .fault_input_a_n_i(flt_n[0]),
    .fault_input_b_n_i(flt_n[1]), .fault_input_c_n_i(flt_n[2]), .osc_stop_i(osc),
    .analog_comparator_i(cmp), .tmr_out_i(tmr_out), .tmr_oe_i(tmr_oe), .pin_o(pin),
    .pin_oe_o(pin_oe), .irq_o(irq));
  pod_tmr_model i_pod_tmr_model (.clk_i(clk_i), .en_i(tm_en), .short_i(shrt),
    .tmr_out_o(tmr_out), .tmr_oe_o(tmr_oe));

  // ****
  // bus tasks and checking
  // ****
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic stop_test();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] s);
    checks++;
    if (s !== ex) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, ex, s);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m, output logic [31:0] q);
    int n;
    exp_q.push_back('{d: w ? 32'h0 : d, m: w ? ALL : m, e: a > `POD_OFS_PINS});
    @(posedge clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++;
      stop_test();
    end
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, 32'h0, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] m);
    logic [31:0] q;
    apb(1'b0, a, ex, m, q);
  endtask

  task automatic wait_stat(input int b);
    logic [31:0] q;
    int n;
    q = 32'h0;
    n = 0;
    while (q[b] !== 1'b1 && n < 1000) begin
      apb(1'b0, `POD_OFS_STAT, 32'h0, 32'h0, q);
      n++;
    end
    if (q[b] !== 1'b1) begin
      err_count++;
      stop_test();
    end
  endtask

  task automatic pulse(input int i, input int len);
    flt_n[i] <= 1'b0;
    repeat (len) @(posedge clk_i);
    flt_n[i] <= 1'b1;
  endtask

  always @(posedge clk_i) begin
    tmr_dly <= tmr_out;
    if (psel && penable && pready === 1'b1) begin
      e = exp_q.pop_front();
      chk("pslverr", {31'h0, e.e}, {31'h0, pslverr});
      if (e.m != 32'h0) chk("prdata", e.d & e.m, prdata & e.m);
      chk("pin_o", {22'h0, tmr_dly}, {22'h0, pin});
    end
  end

  // ****
  // scenarios
  // ****
  initial begin
    int idx;
    int div;
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    for (int a = 0; a <= 28; a += 4) rd(8'(a), 32'h0, ALL);
    wr(8'h20, ALL);
    repeat (4) begin
      lfsr = lfsr_next(lfsr);
      wr(`POD_OFS_MASK, lfsr);
      rd(`POD_OFS_MASK, {24'h0, lfsr[7:0]}, ALL);
    end
    wr(`POD_OFS_MASK, 32'h0);
    wr(`POD_OFS_SWREQ, 32'h1);
    rd(`POD_OFS_PINS, 32'h3F0, ALL);
    wr(`POD_OFS_SWREQ, 32'h2);
    rd(`POD_OFS_PINS, 32'h3F3, ALL);
    chk("pin_oe", 32'h00C, {22'h0, pin_oe});
    wr(`POD_OFS_CH0EN, 32'h3);
    rd(`POD_OFS_PINS, 32'h3FF, ALL);
    wr(`POD_OFS_SWREQ, 32'h0);
    rd(`POD_OFS_PINS, 32'h0, ALL);
    osc <= 1'b1;
    wait_stat(`POD_ST_OSC);
    rd(`POD_OFS_PINS, 32'h3FF, ALL);
    wr(`POD_OFS_STAT, 32'h40);
    rd(`POD_OFS_STAT, 32'h40, 32'h40);
    osc <= 1'b0;
    repeat (4) @(posedge clk_i);
    wr(`POD_OFS_STAT, 32'h40);
    rd(`POD_OFS_PINS, 32'h0, ALL);
    wr(`POD_OFS_CH0EN, 32'h0);
    cmp <= 1'b1;
    wait_stat(`POD_ST_CMP);
    rd(`POD_OFS_PINS, 32'h3F3, ALL);
    cmp <= 1'b0;
    repeat (4) @(posedge clk_i);
    wr(`POD_OFS_STAT, 32'h80);
    rd(`POD_OFS_STAT, 32'h0, ALL);
    // edge, /8, /16 and /128 modes spread over the three inputs
    for (int k = 0; k < 4; k++) begin
      idx = k % 3;
      div = (k == 1) ? 8 : (k == 2) ? 16 : 128;
      wr(`POD_OFS_MODE, 32'(k) << (2 * idx));
      wr(`POD_OFS_MASK, 32'h1 << idx);
      if (k > 0) begin
        pulse(idx, 14 * div);
        repeat (div + 4) @(posedge clk_i);
        rd(`POD_OFS_STAT, 32'h0, 32'h7);
      end
      pulse(idx, (k == 0) ? 2 : 17 * div + 4);
      wait_stat(idx);
      rd(`POD_OFS_PINS, 32'h3F3, ALL);
      chk("irq", 32'h1, {31'h0, irq});
      // a sampled input only lets go of its cause at the first tick after the pin rises
      repeat (div + 4) @(posedge clk_i);
      wr(`POD_OFS_STAT, 32'h1 << idx);
      rd(`POD_OFS_STAT, 32'h0, ALL);
      chk("irq", 32'h0, {31'h0, irq});
    end
    wr(`POD_OFS_ALVL, 32'h3F);
    tm_en <= 1'b1;
    repeat (40) @(posedge clk_i);
    rd(`POD_OFS_STAT, 32'h0, 32'h38);
    for (int p = 0; p < 3; p++) begin
      wr(`POD_OFS_MASK, 32'h8 << p);
      shrt[p] <= 1'b1;
      @(posedge clk_i);
      shrt[p] <= 1'b0;
      wait_stat(`POD_ST_SHORT + p);
      rd(`POD_OFS_STAT, 32'h8 << p, 32'hFF);
      rd(`POD_OFS_PINS, 32'h3 << (4 + 2 * p), 32'h3 << (4 + 2 * p));
      chk("irq", 32'h1, {31'h0, irq});
      wr(`POD_OFS_STAT, 32'h8 << p);
      rd(`POD_OFS_STAT, 32'h0, ALL);
    end
    stop_test();
  end
endmodule
